// ===== rtl/bfs_top.sv
// Top of the buck fault sequencer: state machine, gate commands, AXI4-Lite.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module bfs_top #(
  parameter int unsigned SS_STEPS    = bfs_pkg::SS_STEPS_DEF,
  parameter int unsigned PG_FALL_CYC = bfs_pkg::PG_FALL_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        overcurrent_i,
  input  wire logic        zero_current_i,
  input  wire logic        fb_overvolt_i,
  input  wire logic        fb_undervolt_i,
  input  wire logic        overtemp_i,
  input  wire logic        enable_i,
  input  wire logic        economy_i,
  input  wire logic [4:0]  voltage_select_code_i,
  input  wire logic        pwm_a_i,
  input  wire logic        pwm_b_i,
  output logic [1:0]       high_side_gate_out_o,
  output logic [1:0]       low_side_gate_out_o,
  output logic             softstart_o,
  output logic [4:0]       ref_code_o,
  output logic [5:0]       ss_level_o,
  output logic             output_ok_flag_n_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  initial begin
    if (SS_STEPS < 2 || SS_STEPS > 64) $error("SS_STEPS must be 2 to 64");
  end

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  bfs_pkg::bfs_state_t state_reg;
  bfs_pkg::bfs_state_t state_next;
  logic        ov_latch_reg;
  logic [5:0]  ss_reg;
  logic [1:0]  hs_reg;
  logic [1:0]  ls_reg;
  logic [1:0]  hs_next;
  logic [1:0]  ls_next;
  logic        ctrl_swen_reg;
  logic [15:0] oc_cnt_reg;
  logic [4:0]  code_w;
  logic [11:0] mv_w;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        en_eff;
  logic        ss_done;

  bfs_stat_if stat ();

  // ---------------------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------------------
  bfs_vsel u_vsel (
    .mclk_i                (mclk_i),
    .reset_i               (reset_i),
    .voltage_select_code_i (voltage_select_code_i),
    .code_o                (code_w),
    .setpt_mv_o            (mv_w)
  );

  bfs_pgood #(.FALL_CYCLES(PG_FALL_CYC)) u_pgood (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .fb_low_i (fb_undervolt_i),
    .stat     (stat),
    .ok_n_o   (output_ok_flag_n_o)
  );

  assign en_eff         = enable_i && ctrl_swen_reg;
  assign ss_done        = (ss_reg == 6'(SS_STEPS - 1));
  assign stat.run_ok    = (state_reg == bfs_pkg::BFS_ST_RUN);
  assign stat.disabled  = !en_eff;
  assign stat.setpt_mv  = mv_w;

  // ---------------------------------------------------------------------------
  // Over-voltage latch
  // ---------------------------------------------------------------------------
  // Only the power-on reset clears it; enable and software cannot.
  // over-voltage latch
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ov_latch_reg <= 1'b0;
    end else if (fb_overvolt_i) begin
      ov_latch_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer state machine
  // ---------------------------------------------------------------------------
  // Faults are checked in priority order so a higher fault always wins.
  // fault priority
  always_comb begin
    state_next = state_reg;
    if (ov_latch_reg || fb_overvolt_i) begin
      state_next = bfs_pkg::BFS_ST_OV_LATCH;
    end else if (overtemp_i) begin
      state_next = bfs_pkg::BFS_ST_OT_OFF;
    end else if (overcurrent_i && state_reg != bfs_pkg::BFS_ST_OFF) begin
      state_next = bfs_pkg::BFS_ST_OC_HOLD;
    end else begin
      case (state_reg)
        bfs_pkg::BFS_ST_OFF: begin
          if (en_eff) state_next = bfs_pkg::BFS_ST_SOFTSTART;
        end
        bfs_pkg::BFS_ST_SOFTSTART: begin
          if (!en_eff) state_next = bfs_pkg::BFS_ST_OFF;
          else if (ss_done) state_next = bfs_pkg::BFS_ST_RUN;
        end
        bfs_pkg::BFS_ST_RUN: begin
          if (!en_eff) state_next = bfs_pkg::BFS_ST_OFF;
        end
        bfs_pkg::BFS_ST_OC_HOLD: begin
          if (zero_current_i) begin
            state_next = en_eff ? bfs_pkg::BFS_ST_SOFTSTART : bfs_pkg::BFS_ST_OFF;
          end
        end
        bfs_pkg::BFS_ST_OT_OFF: begin
          // Thermal flag has cleared with hysteresis; restart softly.
          state_next = en_eff ? bfs_pkg::BFS_ST_SOFTSTART : bfs_pkg::BFS_ST_OFF;
        end
        bfs_pkg::BFS_ST_OV_LATCH: begin
          state_next = bfs_pkg::BFS_ST_OV_LATCH;
        end
        default: begin
          state_next = bfs_pkg::BFS_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= bfs_pkg::BFS_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Soft-start ramp counter, restarted from zero at every new entry.
  // full ramp each restart
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ss_reg <= 6'h00;
    end else if (state_reg != bfs_pkg::BFS_ST_SOFTSTART) begin
      ss_reg <= 6'h00;
    end else if (!ss_done) begin
      ss_reg <= ss_reg + 6'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Gate commands
  // ---------------------------------------------------------------------------
  // Index 0 is phase A, index 1 is phase B. Low side is the complement of
  // the PWM while switching; a registered stage keeps the pins glitch free.
  always_comb begin
    hs_next = 2'h0;
    ls_next = 2'h0;
    case (state_reg)
      bfs_pkg::BFS_ST_OV_LATCH, bfs_pkg::BFS_ST_OC_HOLD: begin
        hs_next = 2'h0;
        ls_next = 2'h3;
      end
      bfs_pkg::BFS_ST_SOFTSTART, bfs_pkg::BFS_ST_RUN: begin
        hs_next = {pwm_b_i, pwm_a_i};
        ls_next = {!pwm_b_i, !pwm_a_i};
        if (economy_i) begin
          hs_next[0] = 1'b0;
          ls_next[0] = 1'b0;
        end
      end
      default: begin
        hs_next = 2'h0;
        ls_next = 2'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hs_reg <= 2'h0;
      ls_reg <= 2'h0;
    end else begin
      hs_reg <= hs_next;
      ls_reg <= ls_next;
    end
  end

  assign high_side_gate_out_o = hs_reg;
  assign low_side_gate_out_o  = ls_reg;
  assign softstart_o          = (state_reg == bfs_pkg::BFS_ST_SOFTSTART);
  assign ss_level_o           = ss_reg;
  assign ref_code_o           = code_w;

  // Overcurrent event counter, saturating; visible to software.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      oc_cnt_reg <= 16'h0000;
    end else if (state_next == bfs_pkg::BFS_ST_OC_HOLD && state_reg != bfs_pkg::BFS_ST_OC_HOLD
                 && oc_cnt_reg != 16'hFFFF) begin
      oc_cnt_reg <= oc_cnt_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  // Address and data are captured independently; the write happens when both
  // are held and no response is pending.
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (aw_full_reg && w_full_reg) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // Control register write; only the low byte lane carries a field.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_swen_reg <= bfs_pkg::CTRL_RESET[bfs_pkg::CTRL_SWEN_BIT];
    end else if (aw_full_reg && w_full_reg && aw_addr_reg == bfs_pkg::CTRL_OFFS
                 && w_strb_reg[0]) begin
      ctrl_swen_reg <= w_data_reg[bfs_pkg::CTRL_SWEN_BIT];
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bfs_pkg::RESP_OKAY;
    end else if (aw_full_reg && w_full_reg) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg == bfs_pkg::CTRL_OFFS) ? bfs_pkg::RESP_OKAY
                                                          : bfs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, one cycle from address to data.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= bfs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= bfs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bfs_pkg::CTRL_OFFS:   s_axi_rdata <= {31'h0, ctrl_swen_reg};
        bfs_pkg::STATUS_OFFS: s_axi_rdata <= {22'h0, !output_ok_flag_n_o, ov_latch_reg,
                                               overtemp_i, economy_i, 1'b0, state_reg,
                                               2'h0};
        bfs_pkg::SETPT_OFFS:  s_axi_rdata <= {11'h0, code_w, 4'h0, mv_w};
        bfs_pkg::OVCNT_OFFS:  s_axi_rdata <= {16'h0, oc_cnt_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= bfs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // bfs_top

// ===== rtl/bfs_pkg.sv
// Package of constants, register map and types for the buck fault sequencer.
package bfs_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned PG_FALL_DELAY_US = 500;
  localparam int unsigned PG_FALL_CYCLES   = (PG_FALL_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned VSEL_SKEW_NS     = 500;
  localparam int unsigned VSEL_SKEW_CYCLES =
    (VSEL_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEPS_DEF     = 64;

  // ---------------------------------------------------------------------------
  // Setpoint in millivolts
  // ---------------------------------------------------------------------------
  localparam logic [11:0] SETPT_MIN_MV  = 12'h44C;
  localparam logic [11:0] SETPT_STEP_MV = 12'h019;
  localparam logic [4:0]  VSEL_OFF_CODE = 5'h1F;

  // ---------------------------------------------------------------------------
  // AXI4-Lite register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFFS  = 8'h04;
  localparam logic [7:0]  SETPT_OFFS   = 8'h08;
  localparam logic [7:0]  OVCNT_OFFS   = 8'h0C;
  localparam int unsigned CTRL_SWEN_BIT = 0;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    BFS_ST_OFF,
    BFS_ST_SOFTSTART,
    BFS_ST_RUN,
    BFS_ST_OC_HOLD,
    BFS_ST_OT_OFF,
    BFS_ST_OV_LATCH
  } bfs_state_t;

  // Default mapping: codes 0..30 step upward, code 31 is the off code.
  function automatic logic [11:0] bfs_code_mv(input logic [4:0] code);
    bfs_code_mv = (code == VSEL_OFF_CODE) ? 12'h000
                : 12'(SETPT_MIN_MV + 12'(code) * SETPT_STEP_MV);
  endfunction

endpackage

// ===== rtl/bfs_stat_if.sv
// Interface carrying sequencer status between the modules of the block.
`timescale 1ns/10ps
interface bfs_stat_if;
  logic        run_ok;
  logic        disabled;
  logic [11:0] setpt_mv;
  modport src (output run_ok, output disabled, output setpt_mv);
  modport dst (input run_ok, input disabled, input setpt_mv);
endinterface // bfs_stat_if

// ===== rtl/bfs_pgood.sv
// Power-good monitor with a delayed falling edge.
`timescale 1ns/10ps
module bfs_pgood #(
  parameter int unsigned FALL_CYCLES = bfs_pkg::PG_FALL_CYCLES
) (
  input  wire logic  mclk_i,
  input  wire logic  reset_i,
  input  wire logic  fb_low_i,
  bfs_stat_if.dst    stat,
  output logic       ok_n_o
);
  initial begin
    if (FALL_CYCLES < 1) $error("FALL_CYCLES must be at least one");
  end

  logic [31:0] cnt_reg;
  logic        ok_reg;
  logic        good;

  // Raw level: regulating, not disabled, a valid code, no undervoltage.
  // undervoltage window
  assign good = stat.run_ok && !stat.disabled && (stat.setpt_mv != 12'h000) && !fb_low_i;

  // Rise at once; fall only after the bad level holds for the delay.
  // Disable bypasses the delay so the flag is low for the whole disable.
  // delayed fall only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_reg <= 32'h0000_0000;
      ok_reg  <= 1'b0;
    end else if (good) begin
      cnt_reg <= 32'h0000_0000;
      ok_reg  <= 1'b1;
    end else if (stat.disabled) begin
      cnt_reg <= 32'h0000_0000;
      ok_reg  <= 1'b0;
    end else if (ok_reg) begin
      if (cnt_reg >= FALL_CYCLES - 1) begin
        ok_reg  <= 1'b0;
        cnt_reg <= 32'h0000_0000;
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
      end
    end
  end

  assign ok_n_o = !ok_reg;
endmodule // bfs_pgood

// ===== rtl/bfs_vsel.sv
// Voltage-select decoder with skew filter and parameter lookup table.
`timescale 1ns/10ps
module bfs_vsel #(
  parameter int unsigned SKEW_CYCLES = bfs_pkg::VSEL_SKEW_CYCLES,
  parameter logic [32*12-1:0] CODE_TABLE = '0,
  parameter bit USE_TABLE = 1'b0
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [4:0]  voltage_select_code_i,
  output logic [4:0]       code_o,
  output logic [11:0]      setpt_mv_o
);
  initial begin
    if (SKEW_CYCLES < 1 || SKEW_CYCLES > 255) $error("SKEW_CYCLES must be 1 to 255");
  end

  logic [4:0]  last_reg;
  logic [7:0]  stable_reg;
  logic [4:0]  code_reg;
  logic [11:0] mv_reg;

  // Accept a code only after it has held for the skew window; lines that move
  // one at a time never show their intermediate codes to the reference.
  // skew window filter
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      last_reg   <= bfs_pkg::VSEL_OFF_CODE;
      stable_reg <= 8'h00;
      code_reg   <= bfs_pkg::VSEL_OFF_CODE;
    end else if (voltage_select_code_i != last_reg) begin
      last_reg   <= voltage_select_code_i;
      stable_reg <= 8'h00;
    end else if (stable_reg < 8'(SKEW_CYCLES)) begin
      stable_reg <= stable_reg + 8'h01;
    end else begin
      code_reg <= last_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mv_reg <= 12'h000;
    end else if (USE_TABLE) begin
      mv_reg <= CODE_TABLE[code_reg*12 +: 12];
    end else begin
      mv_reg <= bfs_pkg::bfs_code_mv(code_reg);
    end
  end

  assign code_o     = code_reg;
  assign setpt_mv_o = mv_reg;
endmodule // bfs_vsel

// ===== test/bfs_top_monitor.sv
// Concurrent checks on gate, power-good and enable behaviour at the top ports.
`timescale 1ns/10ps
module bfs_top_monitor (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       overcurrent_i,
  input wire logic       fb_overvolt_i,
  input wire logic       fb_undervolt_i,
  input wire logic       overtemp_i,
  input wire logic       enable_i,
  input wire logic       economy_i,
  input wire logic [1:0] high_side_gate_out_o,
  input wire logic [1:0] low_side_gate_out_o,
  input wire logic       output_ok_flag_n_o
);
  // ------------------------------
  // Properties
  // ------------------------------
  // One clock domain, so clock and reset are given once for all properties.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire [1:0] hs = high_side_gate_out_o;
  wire [1:0] ls = low_side_gate_out_o;

  property p_ov; fb_overvolt_i |-> ##2 (hs == 2'h0 && ls == 2'h3) [*8]; endproperty
  a_ov: assert property (p_ov) else $error("gates not latched by over-voltage");
  property p_ot; overtemp_i |-> ##2 hs == 2'h0 && (ls == 2'h0 || ls == 2'h3); endproperty
  a_ot: assert property (p_ot) else $error("switching not off on over-temp");
  property p_oc;
    (overcurrent_i && !fb_overvolt_i && hs != 2'h0 && enable_i && $past(enable_i))
      ##0 !overtemp_i [*3] |-> ##[1:3] (hs == 2'h0 && ls == 2'h3);
  endproperty
  a_oc: assert property (p_oc) else $error("no gate hold after overcurrent");
  property p_eco; economy_i [*3] |-> !hs[0] && (!ls[0] || ls == 2'h3); endproperty
  a_eco: assert property (p_eco) else $error("phase A driven in economy");
  property p_en_sw; !enable_i [*2] |-> ##1 hs == 2'h0; endproperty
  a_en_sw: assert property (p_en_sw) else $error("switching while disabled");
  property p_en_pg; !enable_i [*2] |-> ##1 output_ok_flag_n_o; endproperty
  a_en_pg: assert property (p_en_pg) else $error("power good while disabled");
  property p_pg_fall;
    $rose(fb_undervolt_i) && !output_ok_flag_n_o ##0 enable_i [*6] |-> !output_ok_flag_n_o;
  endproperty
  a_pg_fall: assert property (p_pg_fall) else $error("power good fell too soon");
  property p_pg_rise;
    $fell(output_ok_flag_n_o) |-> $past(enable_i) && !$past(fb_undervolt_i);
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("power good with low output");
endmodule // bfs_top_monitor

bind bfs_top bfs_top_monitor u_mon (.mclk_i, .reset_i, .overcurrent_i, .fb_overvolt_i,
  .fb_undervolt_i, .overtemp_i, .enable_i, .economy_i, .high_side_gate_out_o,
  .low_side_gate_out_o, .output_ok_flag_n_o);

// ===== test/bfs_fet_model.sv
// Model of the external power stage: inductor current after a trip.
`timescale 1ns/10ps
module bfs_fet_model #(
  parameter int unsigned DECAY = 6
) (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       overcurrent_i,
  input  wire logic [1:0] ls_i,
  output logic            zero_current_o
);
  logic [7:0] cur_reg;

  // A trip loads the current; it bleeds off only while both low sides conduct,
  // so a design that lets go of the low sides early never sees zero current.
  always_ff @(posedge mclk_i) begin
    if (reset_i) cur_reg <= 8'h00;
    else if (overcurrent_i) cur_reg <= 8'(DECAY);
    else if (ls_i == 2'h3 && cur_reg != 8'h00) cur_reg <= cur_reg - 8'h01;
  end
  assign zero_current_o = (cur_reg == 8'h00);
endmodule // bfs_fet_model

// ===== test/bfs_top_tb_top.sv
// Self-checking bench for the buck fault sequencer top.
`timescale 1ns/10ps
module bfs_top_tb_top;
  logic        clk = 1'b0, rst = 1'b1, oc = 1'b0, ov = 1'b0, uv = 1'b0;
  logic        ot = 1'b0, en = 1'b1, eco = 1'b0, pwm_a = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [4:0]  vsel = 5'h0A;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  wire         zc, ss, pg_n, awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  hs, ls, bresp, rresp;
  wire  [31:0] rdata;
  wire  [4:0]  rcode;
  wire  [5:0]  ss_lvl;
  int          n_errors = 0, cmp_count = 0;

  // ------------------------------
  // Clock, PWM and instances
  // ------------------------------
  // Short soft-start and fall delay keep the run brief.
  always #50 clk = ~clk;
  always @(posedge clk) pwm_a <= ~pwm_a;
  bfs_top #(.SS_STEPS(4), .PG_FALL_CYC(20)) DUT (
    .mclk_i(clk), .reset_i(rst), .overcurrent_i(oc), .zero_current_i(zc),
    .fb_overvolt_i(ov), .fb_undervolt_i(uv), .overtemp_i(ot), .enable_i(en),
    .economy_i(eco), .voltage_select_code_i(vsel), .pwm_a_i(pwm_a), .pwm_b_i(~pwm_a),
    .high_side_gate_out_o(hs), .low_side_gate_out_o(ls), .softstart_o(ss),
    .ref_code_o(rcode), .ss_level_o(ss_lvl), .output_ok_flag_n_o(pg_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  bfs_fet_model #(.DECAY(6)) u_fet (.mclk_i(clk), .reset_i(rst), .overcurrent_i(oc),
    .ls_i(ls), .zero_current_o(zc));

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for soft-start (pg=0) or for power good (pg=1).
  task automatic wait_on(input bit pg, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      cyc(1);
      if (pg ? pg_n === 1'b0 : ss === 1'b1) break;
    end
    chk(32'(i < lim), 32'h1, "wait bound");
    if (i == lim) print_verdict();
  endtask
  // Address and data go out together; each is dropped once taken.
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, er, "write response");
    chk(32'(i < 40), 32'h1, "write bound");
    if (i == 40) print_verdict();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    int i;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(rdata & m, e, "read data");
    chk(rresp, er, "read response");
    chk(32'(i < 40), 32'h1, "read bound");
    if (i == 40) print_verdict();
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_start();
    wait_on(1'b0, 60);
    cyc(3);
    chk({ss, ss_lvl}, 7'h43, "ramp top");
    wait_on(1'b1, 200);
    rd_chk(8'h00, 32'hFFFF_FFFF, 32'h1, 2'h0);
    $display("start done");
  endtask
  // Codes change on all lines at one edge; code 31 is the off code.
  task automatic t_code();
    logic [4:0]  codes [3] = '{5'h00, 5'h1E, 5'h1F};
    logic [11:0] mv;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) vsel <= codes[k];
      cyc(12);
      chk(rcode, codes[k], "accepted code");
      mv = (codes[k] == 5'h1F) ? 12'h000 : 12'(1100 + 25 * codes[k]);
      rd_chk(8'h08, 32'h001F_0FFF, {11'h0, codes[k], 4'h0, mv}, 2'h0);
    end
    chk(pg_n, 1'b0, "held through delay");
    cyc(20);
    chk(pg_n, 1'b1, "off code");
    @(posedge clk) vsel <= 5'h0A;
    wait_on(1'b1, 40);
    $display("code done");
  endtask
  task automatic t_uv();
    @(posedge clk) uv <= 1'b1;
    cyc(15);
    chk(pg_n, 1'b0, "fall delayed");
    cyc(10);
    chk(pg_n, 1'b1, "under-voltage");
    chk(32'(hs != 2'h0), 32'h1, "still switching");
    @(posedge clk) uv <= 1'b0;
    wait_on(1'b1, 5);
    $display("undervolt done");
  endtask
  task automatic t_oc();
    @(posedge clk) oc <= 1'b1;
    @(posedge clk) oc <= 1'b0;
    cyc(2);
    chk({zc, hs, ls}, 5'h03, "trip hold");
    cyc(3);
    chk({zc, hs, ls}, 5'h03, "hold until zero");
    wait_on(1'b0, 20);
    wait_on(1'b1, 200);
    rd_chk(8'h0C, 32'h0000_FFFF, 32'h1, 2'h0);
    $display("overcurrent done");
  endtask
  task automatic t_eco();
    logic seen;
    @(posedge clk) eco <= 1'b1;
    cyc(3);
    seen = 1'b0;
    repeat (8) begin
      chk({hs[0], ls[0]}, 2'h0, "phase A idle");
      seen = seen | hs[1];
      cyc(1);
    end
    chk(seen, 1'b1, "phase B runs");
    @(posedge clk) eco <= 1'b0;
    $display("economy done");
  endtask
  task automatic t_dis();
    @(posedge clk) en <= 1'b0;
    cyc(3);
    chk({pg_n, hs}, 3'h4, "disabled");
    @(posedge clk) en <= 1'b1;
    wait_on(1'b0, 20);
    wait_on(1'b1, 60);
    wr_chk(8'h00, 32'h0, 2'h0);
    cyc(3);
    chk(pg_n, 1'b1, "soft disable");
    wr_chk(8'h00, 32'h1, 2'h0);
    wait_on(1'b1, 60);
    wr_chk(8'h04, 32'hFFFF_FFFF, 2'h2);
    rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0, 2'h2);
    $display("disable done");
  endtask
  task automatic t_ot();
    @(posedge clk) begin
      ot <= 1'b1;
      oc <= 1'b1;
    end
    @(posedge clk) oc <= 1'b0;
    cyc(3);
    chk({hs, ls}, 4'h0, "heat off");
    @(posedge clk) ot <= 1'b0;
    wait_on(1'b0, 20);
    wait_on(1'b1, 100);
    $display("overtemp done");
  endtask
  task automatic t_ov();
    @(posedge clk) ov <= 1'b1;
    @(posedge clk) ov <= 1'b0;
    cyc(2);
    chk({hs, ls}, 4'h3, "ov latch");
    @(posedge clk) en <= 1'b0;
    @(posedge clk) en <= 1'b1;
    cyc(30);
    chk({hs, ls}, 4'h3, "latch holds");
    rd_chk(8'h04, 32'h0000_03DC, 32'h0000_0114, 2'h0);
    $display("overvolt done");
  endtask

  // Main sequence; the latch test goes last since only reset clears it.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_start();
    t_code();
    t_uv();
    t_oc();
    t_eco();
    t_dis();
    t_ot();
    t_ov();
    print_verdict();
  end
endmodule // bfs_top_tb_top
